/* hdl/adc_config_regs_zero_one.sv */
// Configuration bank holding the first two converter configuration bytes.
// Assumes a classic Wishbone master on clk_i and a conversion core that reads the outputs.
//
// Overview of operation
// - The second byte sits at index 01h (byte address 04h) and resets to zero.
// - The first byte sits at index 00h (byte address 00h) and resets to zero.
// - Bits 7:5 of the second byte pick the data rate, read against the current mode.
// - The mode bit picks a 256 kHz modulator clock at 0 and 512 kHz at 1.
// - The repeat bit picks single-shot at 0 and continuous conversion at 1.
// - Reference code 00 is internal, 01 external pins, 10 and 11 the analog supply.
// - The temperature bit set to 1 selects temperature measurement mode.
// - In temperature mode the first byte is ignored and the internal reference forced.
// - The bypass bit acts only for gains 1, 2 and 4; at 0 the amplifier stays in.
// - Gains 8 to 128 keep the amplifier on whatever the bypass bit holds.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
module adc_config_regs_zero_one (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [3:0] input_select_o,
  output logic [2:0] gain_o,
  output logic amplifier_on_o,
  output logic [2:0] rate_select_o,
  output logic turbo_mode_o,
  output logic conversion_repeat_o,
  output logic [1:0] reference_o,
  output logic temperature_sense_enable_o
);
  typedef struct packed {
    logic [7:0] input_gain;
    logic [7:0] rate_mode;
    logic ack;
    logic [31:0] rdata;
    logic [3:0] input_select;
    logic [2:0] gain;
    logic amp_on;
    logic [2:0] rate;
    logic turbo;
    logic repeat_on;
    logic [1:0] reference;
    logic ts;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [3:0] eff_sel;
  logic [2:0] eff_gain;
  logic eff_amp;
  logic [1:0] eff_ref;
  logic eff_ts;
  logic wr_req;
  logic [7:0] gain_byte_next;
  logic [7:0] rate_byte_next;

  // Effective values come from the bytes being registered, so the outputs change on the same edge that writes the byte.
  cfg_effective u_eff (
    .input_gain_i(gain_byte_next),
    .rate_mode_i(rate_byte_next),
    .input_select_o(eff_sel),
    .gain_o(eff_gain),
    .amplifier_on_o(eff_amp),
    .reference_o(eff_ref),
    .temperature_sense_enable_o(eff_ts)
  );

  function automatic logic [31:0] word_of(input logic [7:0] b);
    word_of = {24'h00_0000, b};
  endfunction : word_of

  function automatic logic [7:0] byte_next(input logic [7:0] cur, input logic hit, input logic [7:0] d);
    byte_next = hit ? d : cur;
  endfunction : byte_next

  // The next bytes are nets of their own so the resolver does not loop back through the state copy.
  // A write with lane 0 cleared leaves both bytes untouched.
  assign wr_req = wb_cyc_i && wb_stb_i && !state_reg.ack && wb_we_i && wb_sel_i[0];
  assign gain_byte_next = byte_next(state_reg.input_gain, wr_req && (wb_adr_i == cfg_bank_pkg::ADDR_INPUT_GAIN),
                                    wb_dat_i[7:0]);
  assign rate_byte_next = byte_next(state_reg.rate_mode, wr_req && (wb_adr_i == cfg_bank_pkg::ADDR_RATE_MODE),
                                    wb_dat_i[7:0]);

  always_comb begin
    logic req;
    req = 1'b0;
    state_next = state_reg;
    req = wb_cyc_i && wb_stb_i && !state_reg.ack;
    state_next.ack = req;
    state_next.input_gain = gain_byte_next;
    state_next.rate_mode = rate_byte_next;
    if (req && !wb_we_i) begin
      if (wb_adr_i == cfg_bank_pkg::ADDR_INPUT_GAIN) begin
        state_next.rdata = word_of(state_reg.input_gain);
      end else if (wb_adr_i == cfg_bank_pkg::ADDR_RATE_MODE) begin
        state_next.rdata = word_of(state_reg.rate_mode);
      end else if (wb_adr_i == cfg_bank_pkg::ADDR_EFFECTIVE) begin
        state_next.rdata = word_of({state_reg.input_select[3:0], state_reg.amp_on,
                                    state_reg.reference, state_reg.ts});
      end else begin
        state_next.rdata = cfg_bank_pkg::UNMAPPED_DATA;
      end
    end
    state_next.input_select = eff_sel;
    state_next.gain = eff_gain;
    state_next.amp_on = eff_amp;
    state_next.reference = eff_ref;
    state_next.ts = eff_ts;
    state_next.rate = state_next.rate_mode[cfg_bank_pkg::RATE_SELECT_LSB +: 3];
    state_next.turbo = state_next.rate_mode[cfg_bank_pkg::TURBO_BIT];
    state_next.repeat_on = state_next.rate_mode[cfg_bank_pkg::CONVERSION_REPEAT_BIT];
    if (rst_i) begin
      state_next = '0;
      state_next.input_gain = cfg_bank_pkg::RESET_INPUT_GAIN;
      state_next.rate_mode = cfg_bank_pkg::RESET_RATE_MODE;
      state_next.amp_on = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    state_reg <= state_next;
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdata;
  assign input_select_o = state_reg.input_select;
  assign gain_o = state_reg.gain;
  assign amplifier_on_o = state_reg.amp_on;
  assign rate_select_o = state_reg.rate;
  assign turbo_mode_o = state_reg.turbo;
  assign conversion_repeat_o = state_reg.repeat_on;
  assign reference_o = state_reg.reference;
  assign temperature_sense_enable_o = state_reg.ts;

  property p_reset_zero;
    @(posedge clk_i) rst_i |=> (state_reg.input_gain == 8'h00 && state_reg.rate_mode == 8'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("bytes not zero after reset");

  property p_reset_outputs;
    @(posedge clk_i) rst_i |=> (amplifier_on_o && reference_o == 2'h0 && !wb_ack_o && rate_select_o == 3'h0
      && !temperature_sense_enable_o && input_select_o == 4'h0);
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not idle after reset");

  property p_write_first;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && wb_adr_i == 32'h0)
      |=> (state_reg.input_gain == $past(wb_dat_i[7:0]));
  endproperty
  a_write_first: assert property (p_write_first) else $error("first byte write lost");

  property p_write_second;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && wb_adr_i == 32'h4)
      |=> (state_reg.rate_mode == $past(wb_dat_i[7:0]));
  endproperty
  a_write_second: assert property (p_write_second) else $error("second byte write lost");

  property p_sel_ignored;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && wb_we_i && !wb_sel_i[0]) |=> ($stable(state_reg.input_gain)
      && $stable(state_reg.rate_mode));
  endproperty
  a_sel_ignored: assert property (p_sel_ignored) else $error("write without lane zero changed a byte");

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

  property p_rate;
    @(posedge clk_i) disable iff (rst_i) ##1 rate_select_o == state_reg.rate_mode[7:5];
  endproperty
  a_rate: assert property (p_rate) else $error("rate field mismatch");

  property p_turbo;
    @(posedge clk_i) disable iff (rst_i) turbo_mode_o == state_reg.rate_mode[4];
  endproperty
  a_turbo: assert property (p_turbo) else $error("mode bit mismatch");

  property p_repeat;
    @(posedge clk_i) disable iff (rst_i) conversion_repeat_o == state_reg.rate_mode[3];
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat bit mismatch");

  property p_ref_supply;
    @(posedge clk_i) disable iff (rst_i) (state_reg.rate_mode[2] && !state_reg.rate_mode[0]) |-> reference_o == 2'h2;
  endproperty
  a_ref_supply: assert property (p_ref_supply) else $error("supply reference not chosen");

  property p_ref_external;
    @(posedge clk_i) disable iff (rst_i)
      (state_reg.rate_mode[2:1] == 2'h1 && !state_reg.rate_mode[0]) |-> reference_o == 2'h1;
  endproperty
  a_ref_external: assert property (p_ref_external) else $error("external reference not chosen");

  property p_ref_internal;
    @(posedge clk_i) disable iff (rst_i) (state_reg.rate_mode[2:1] == 2'h0) |-> reference_o == 2'h0;
  endproperty
  a_ref_internal: assert property (p_ref_internal) else $error("internal reference not chosen");

  property p_ts_forward;
    @(posedge clk_i) disable iff (rst_i) temperature_sense_enable_o == state_reg.rate_mode[0];
  endproperty
  a_ts_forward: assert property (p_ts_forward) else $error("temperature flag mismatch");

  property p_ts_ignores;
    @(posedge clk_i) disable iff (rst_i) state_reg.rate_mode[0] |-> (input_select_o == 4'h0 && gain_o == 3'h0);
  endproperty
  a_ts_ignores: assert property (p_ts_ignores) else $error("first byte used in temperature mode");

  property p_select_forward;
    @(posedge clk_i) disable iff (rst_i)
      !state_reg.rate_mode[0] |-> (input_select_o == state_reg.input_gain[7:4] && gain_o == state_reg.input_gain[3:1]);
  endproperty
  a_select_forward: assert property (p_select_forward) else $error("first byte fields not forwarded");

  property p_ts_ref;
    @(posedge clk_i) disable iff (rst_i) state_reg.rate_mode[0] |-> (reference_o == 2'h0 && amplifier_on_o
      && temperature_sense_enable_o);
  endproperty
  a_ts_ref: assert property (p_ts_ref) else $error("temperature mode not forcing internal reference");

  property p_high_gain;
    @(posedge clk_i) disable iff (rst_i) (state_reg.input_gain[3:1] > 3'h2) |-> amplifier_on_o;
  endproperty
  a_high_gain: assert property (p_high_gain) else $error("amplifier off at high gain");

  property p_bypass;
    @(posedge clk_i) disable iff (rst_i)
      (!state_reg.rate_mode[0] && state_reg.input_gain[3:1] <= 3'h2) |-> amplifier_on_o == !state_reg.input_gain[0];
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not honoured at low gain");

  property p_readback;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 32'h0)
      |=> wb_ack_o && wb_dat_o == {24'h0, $past(state_reg.input_gain)};
  endproperty
  a_readback: assert property (p_readback) else $error("first byte readback wrong");

  property p_readback_second;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 32'h4)
      |=> wb_ack_o && wb_dat_o == {24'h0, $past(state_reg.rate_mode)};
  endproperty
  a_readback_second: assert property (p_readback_second) else $error("second byte readback wrong");

  property p_status_read;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 32'h8)
      |=> wb_dat_o == {24'h0, $past(input_select_o), $past(amplifier_on_o), $past(reference_o),
      $past(temperature_sense_enable_o)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status readback wrong");

  property p_unmapped;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i != 32'h0 && wb_adr_i != 32'h4
      && wb_adr_i != 32'h8) |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : adc_config_regs_zero_one

/* hdl/cfg_bank_pkg.sv */
// Constants for the two-byte converter configuration bank.
// Assumes a 32-bit classic Wishbone slave with byte address decode.
package cfg_bank_pkg;
  localparam logic [7:0] IDX_INPUT_GAIN = 8'h00;
  localparam logic [7:0] IDX_RATE_MODE = 8'h01;
  localparam logic [31:0] ADDR_INPUT_GAIN = 32'h0000_0000;
  localparam logic [31:0] ADDR_RATE_MODE = 32'h0000_0004;
  localparam logic [31:0] ADDR_EFFECTIVE = 32'h0000_0008;
  localparam logic [7:0] RESET_INPUT_GAIN = 8'h00;
  localparam logic [7:0] RESET_RATE_MODE = 8'h00;
  localparam int INPUT_SELECT_LSB = 4;
  localparam int GAIN_LSB = 1;
  localparam int AMPLIFIER_SKIP_BIT = 0;
  localparam int RATE_SELECT_LSB = 5;
  localparam int TURBO_BIT = 4;
  localparam int CONVERSION_REPEAT_BIT = 3;
  localparam int REFERENCE_LSB = 1;
  localparam int TEMPERATURE_SENSE_BIT = 0;
  localparam logic [2:0] GAIN_CODE_4 = 3'h2;
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_EXTERNAL = 2'h1;
  localparam logic [1:0] REF_SUPPLY = 2'h2;
  localparam int MOD_CLK_NORMAL_KHZ = 256;
  localparam int MOD_CLK_TURBO_KHZ = 512;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : cfg_bank_pkg

/* hdl/cfg_effective.sv */
// Combinational resolution of what the conversion core really uses.
// Assumes raw register bytes from the same clock domain.
`timescale 1ns/1ps
module cfg_effective (
  input wire logic [7:0] input_gain_i,
  input wire logic [7:0] rate_mode_i,
  output logic [3:0] input_select_o,
  output logic [2:0] gain_o,
  output logic amplifier_on_o,
  output logic [1:0] reference_o,
  output logic temperature_sense_enable_o
);
  logic ts;
  logic [2:0] gain_raw;
  assign ts = rate_mode_i[cfg_bank_pkg::TEMPERATURE_SENSE_BIT];
  assign gain_raw = input_gain_i[cfg_bank_pkg::GAIN_LSB +: 3];
  assign temperature_sense_enable_o = ts;
  always_comb begin
    input_select_o = ts ? 4'h0 : input_gain_i[cfg_bank_pkg::INPUT_SELECT_LSB +: 4];
    gain_o = ts ? 3'h0 : gain_raw;
    if (ts) begin
      amplifier_on_o = 1'b1;
    end else if (gain_raw > cfg_bank_pkg::GAIN_CODE_4) begin
      amplifier_on_o = 1'b1;
    end else begin
      amplifier_on_o = ~input_gain_i[cfg_bank_pkg::AMPLIFIER_SKIP_BIT];
    end
    if (ts) begin
      reference_o = cfg_bank_pkg::REF_INTERNAL;
    end else if (rate_mode_i[cfg_bank_pkg::REFERENCE_LSB +: 2] >= cfg_bank_pkg::REF_SUPPLY) begin
      reference_o = cfg_bank_pkg::REF_SUPPLY;
    end else begin
      reference_o = rate_mode_i[cfg_bank_pkg::REFERENCE_LSB +: 2];
    end
  end
endmodule : cfg_effective

/* tb/test_adc_config_regs_zero_one.sv */
// Self-checking bench for the two-byte converter configuration bank.
// Assumes the bank answers every classic Wishbone request with a single ack.
`timescale 1ns/1ps
module test_adc_config_regs_zero_one;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [31:0] wb_adr = 32'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] input_select_o;
  logic [2:0] gain_o;
  logic amplifier_on_o;
  logic [2:0] rate_select_o;
  logic turbo_mode_o;
  logic conversion_repeat_o;
  logic [1:0] reference_o;
  logic temperature_sense_enable_o;
  logic [15:0] outs;
  int fail_count = 0;
  int tests_run = 0;
  assign outs = {input_select_o, gain_o, amplifier_on_o, rate_select_o, turbo_mode_o,
                 conversion_repeat_o, reference_o, temperature_sense_enable_o};
  always #2 clk_i = ~clk_i;
  adc_config_regs_zero_one adc_config_regs_zero_one_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .input_select_o(input_select_o),
    .gain_o(gain_o), .amplifier_on_o(amplifier_on_o), .rate_select_o(rate_select_o),
    .turbo_mode_o(turbo_mode_o), .conversion_repeat_o(conversion_repeat_o),
    .reference_o(reference_o), .temperature_sense_enable_o(temperature_sense_enable_o));
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until ack is sampled high, then releases and idles a cycle.
  task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d, input logic [3:0] s,
                      output logic [31:0] r);
    int n;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} <= {2'b11, w, a, 24'h0, d, s};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      wrap_up();
    end else begin
      r = wb_dat_o;
      {wb_cyc, wb_stb, wb_we} <= 3'b000;
      @(posedge clk_i);
    end
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, 4'h1, r);
  endtask : wr
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 8'h00, 4'h1, r);
    chk(r, exp);
  endtask : rd_chk
  task automatic t_reset;
    rd_chk(cfg_bank_pkg::ADDR_INPUT_GAIN, 32'h0);
    rd_chk(cfg_bank_pkg::ADDR_RATE_MODE, 32'h0);
    chk({16'h0, outs}, {16'h0, 4'h0, 3'h0, 1'b1, 8'h00});
  endtask : t_reset
  task automatic t_first;
    wr(cfg_bank_pkg::ADDR_INPUT_GAIN, 8'ha5);
    rd_chk(cfg_bank_pkg::ADDR_INPUT_GAIN, 32'ha5);
    chk({16'h0, outs}, {16'h0, 4'ha, cfg_bank_pkg::GAIN_CODE_4, 1'b0, 8'h00});
    for (int g = 0; g < 8; g++) begin
      wr(cfg_bank_pkg::ADDR_INPUT_GAIN, {4'h3, g[2:0], 1'b1});
      chk({16'h0, outs[15:8]}, {16'h0, 4'h3, g[2:0], g > 2});
    end
    wr(cfg_bank_pkg::ADDR_INPUT_GAIN, 8'h04);
    chk({31'h0, amplifier_on_o}, 32'h1);
  endtask : t_first
  task automatic t_second;
    for (int v = 0; v < 4; v++) begin
      wr(cfg_bank_pkg::ADDR_RATE_MODE, {3'h6, 2'b11, v[1:0], 1'b0});
      chk({24'h0, outs[7:0]}, {24'h0, 3'h6, 2'b11, (v > 1) ? 2'h2 : v[1:0], 1'b0});
    end
    rd_chk(cfg_bank_pkg::ADDR_RATE_MODE, 32'hde);
    wr(cfg_bank_pkg::ADDR_RATE_MODE, 8'ha0);
    chk({24'h0, outs[7:0]}, {24'h0, 8'ha0});
  endtask : t_second
  task automatic t_temp;
    wr(cfg_bank_pkg::ADDR_INPUT_GAIN, 8'ha5);
    wr(cfg_bank_pkg::ADDR_RATE_MODE, 8'h03);
    chk({16'h0, outs}, {16'h0, 4'h0, 3'h0, 1'b1, 3'h0, 2'b00, cfg_bank_pkg::REF_INTERNAL, 1'b1});
    rd_chk(cfg_bank_pkg::ADDR_EFFECTIVE, 32'h09);
    rd_chk(cfg_bank_pkg::ADDR_INPUT_GAIN, 32'ha5);
    wr(cfg_bank_pkg::ADDR_RATE_MODE, 8'h02);
    chk({16'h0, outs}, {16'h0, 4'ha, 3'h2, 1'b0, 5'h00, cfg_bank_pkg::REF_EXTERNAL, 1'b0});
    rd_chk(cfg_bank_pkg::ADDR_EFFECTIVE, 32'ha2);
  endtask : t_temp
  // A second reset in mid-run must clear both bytes and return the field outputs to their reset values, with the amplifier on.
  task automatic t_rereset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(cfg_bank_pkg::ADDR_RATE_MODE, 32'h0);
    rd_chk(cfg_bank_pkg::ADDR_INPUT_GAIN, 32'h0);
    chk({16'h0, outs}, {16'h0, 4'h0, 3'h0, 1'b1, 8'h00});
  endtask : t_rereset
  task automatic t_refused;
    logic [31:0] r;
    xfer(cfg_bank_pkg::ADDR_INPUT_GAIN, 1'b1, 8'hff, 4'he, r);
    rd_chk(cfg_bank_pkg::ADDR_INPUT_GAIN, 32'ha5);
    rd_chk(32'h0000_0010, cfg_bank_pkg::UNMAPPED_DATA);
  endtask : t_refused
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_first();
    t_second();
    t_temp();
    t_refused();
    t_rereset();
    wrap_up();
  end
endmodule : test_adc_config_regs_zero_one
